// file: logic/uci_cfg.svh
/*
  Offsets, field positions, reset values, status codes and timing figures of one
  UART channel's interrupt and status logic.
  Assumes it is included by bare name from design files of this block only.
*/
`ifndef UCI_CFG_SVH
`define UCI_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UCI_OFS_HOLDING 4'h0
`define UCI_OFS_IRQ_ENABLE 4'h1
`define UCI_OFS_IRQ_STATUS 4'h2
`define UCI_OFS_LINE_CONTROL 4'h3
`define UCI_OFS_MODEM_CONTROL 4'h4
`define UCI_OFS_LINE_STATUS 4'h5
`define UCI_OFS_MODEM_STATUS 4'h6
`define UCI_OFS_SCRATCH 4'h7
`define UCI_OFS_FEATURE_CONTROL 4'h8
`define UCI_OFS_ENHANCED 4'h9
`define UCI_OFS_RESERVED_A 4'ha
`define UCI_OFS_RESERVED_B 4'hb
`define UCI_OFS_FLOW_IND 4'hc
`define UCI_OFS_PAUSE_SECOND 4'hd
`define UCI_OFS_RESUME_FIRST 4'he
`define UCI_OFS_RESUME_SECOND 4'hf

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UCI_RST_IRQ_ENABLE 8'h00
`define UCI_RST_CTRL 8'h00
`define UCI_RST_CHAR 8'h00
`define UCI_RST_TRIG_SEL 2'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UCI_IER_RXDATA 0
`define UCI_IER_TX_READY_IRQ 1
`define UCI_IER_LINE 2
`define UCI_IER_MODEM 3
`define UCI_IER_PAUSE 5
`define UCI_IER_OUT_FLOW 6
`define UCI_IER_IN_FLOW 7
`define UCI_EFR_ENH 4
`define UCI_EFR_AUTO_OUT 6
`define UCI_EFR_AUTO_IN 7
`define UCI_FEATURE_CONTROL_HALF_DUPLEX 5
`define UCI_MCR_DTR 0
`define UCI_MCR_RTS 1
`define UCI_MCR_FLOW_SEL 2
`define UCI_FCR_ENABLE 0
`define UCI_FCR_RX_RESET 1
`define UCI_FCR_TX_RESET 2

// ----------------------------------------------------------------------------
// Status codes, highest priority first
// ----------------------------------------------------------------------------
`define UCI_CODE_LINE 6'h06
`define UCI_CODE_RXDATA 6'h04
`define UCI_CODE_TIMEOUT 6'h0c
`define UCI_CODE_TX_READY_IRQ 6'h02
`define UCI_CODE_MODEM 6'h00
`define UCI_CODE_PAUSE 6'h10
`define UCI_CODE_FLOW_CHG 6'h20
`define UCI_CODE_NONE 6'h01

// ----------------------------------------------------------------------------
// Trigger levels and receive time-out, in characters and bit times
// ----------------------------------------------------------------------------
`define UCI_TRIG_0 5'd1
`define UCI_TRIG_1 5'd4
`define UCI_TRIG_2 5'd8
`define UCI_TRIG_3 5'd14
`define UCI_TOUT_CHARS 4
`define UCI_TOUT_BITS 12

`endif

// file: logic/uci_pkg.sv
/*
  Types carried between the channel interrupt logic and its neighbours.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package uci_pkg;

  // Received character with its error flags in the low bits
  typedef struct packed {
    logic [7:0] data;
    logic brk;
    logic framing;
    logic parity;
  } uci_rx_char_t;

  // Active-low modem input pins
  typedef struct packed {
    logic dcdN;
    logic riN;
    logic dsrN;
    logic ctsN;
  } uci_modem_pins_t;

  // One-cycle events from the software flow-control engine
  typedef struct packed {
    logic txResume;
    logic txPause;
    logic rxResume;
    logic rxPause;
  } uci_flow_evt_t;

  // Programmed flow-control characters
  typedef struct packed {
    logic [7:0] pauseFirst;
    logic [7:0] pauseSecond;
    logic [7:0] resumeFirst;
    logic [7:0] resumeSecond;
  } uci_flow_chars_t;

endpackage

// file: logic/uci_rx_fifo.sv
/*
  Receive FIFO storage with a registered head word.
  Assumes DEPTH is a power of two and the caller never pops an empty FIFO on purpose.
*/
`timescale 1ns/1ps
module uci_rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16,
  parameter int LW = $clog2(DEPTH) + 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control
  input wire logic flush,
  input wire logic [LW-1:0] limit,
  // Write side
  input wire logic pushValid,
  input wire logic [WIDTH-1:0] pushData,
  // Read side
  input wire logic popReq,
  output logic [WIDTH-1:0] headData_q,
  output logic [LW-1:0] level_q
);

  localparam int AW = LW - 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW-1:0] rdPtr_d;
  logic doPush;
  logic doPop;

  assign doPush = pushValid && (level_q < limit);
  assign doPop = popReq && (level_q != '0);
  assign rdPtr_d = doPop ? rdPtr_q + 1'b1 : rdPtr_q;

  always_ff @(posedge sys_clk)
  begin
    if (doPush)
    begin
      mem[wrPtr_q] <= pushData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      rdPtr_q <= rdPtr_d;
      level_q <= level_q + LW'(doPush) - LW'(doPop);
    end
  end

  // Head word forwards a write that lands on the next read slot
  always_ff @(posedge sys_clk)
  begin
    if (srst || flush)
    begin
      headData_q <= '0;
    end
    else if (doPush && (wrPtr_q == rdPtr_d))
    begin
      headData_q <= pushData;
    end
    else
    begin
      headData_q <= mem[rdPtr_d];
    end
  end

endmodule

// file: logic/uci_channel_irq.sv
/*
  Interrupt enable, priority and status logic of one UART channel, with the receive
  FIFO flags, line and modem status and the software flow-control character registers.
  Assumes synchronous inputs, a baud generator giving one bitTick per bit time, a
  serialiser that pulses txPop when it takes a byte, and a flow engine giving events.
*/
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "uci_cfg.svh"

// What this block does
// - Flow indicator read gives tx-resume, tx-pause, resume-seen, pause-seen; read clears them.
// - Mask bits 7..5 are writable and act only while enhanced bit 4 is set.
// - Channel interrupt code is mirrored out to the device-level summary.
// - In FIFO mode receive interrupt follows level at or above trigger.
// - Data-ready status sets on a character entering the FIFO, clears when empty.
// - Line status shows overrun, head errors, transmit empties and any FIFO error.
// - With FIFOs on and mask 3..0 clear, software polls line status bits.
// - Mask bit 7 raises interrupt on clear-to-send pin rising; off by default.
// - Mask bit 6 raises interrupt on request-to-send pin rising; off by default.
// - Mask bit 5 enables pause-character interrupt, off by default; bit 4 reserved.
// - Mask bit 3 raises modem interrupt when any modem delta bit is set.
// - Line interrupt on errored arrival, and again when it reaches the FIFO head.
// - Error bits describe the head byte; bit 7 flags an errored character anywhere in the FIFO, head included.
// - Transmit interrupt on empty holding, or below-trigger and empty in FIFO mode.
// - Half-duplex mode delays the empty event until the shifter empties; a fall below trigger, so any emptying at trigger 1, still interrupts at once.
// - Mask bit 0 enables receive interrupt on data or trigger level reached.
// - All interrupt enables are off after reset.
// - Status read gives highest pending code; lower ones wait their turn.
// - In FIFO mode, receive time-out fires after four character times plus twelve bit times.
// - Input flow pin rising interrupts only under auto input flow; select picks pin.
// - Output flow pin rising interrupts only under auto output flow; select picks pin.
// - Reading line status clears the line status interrupt.
// - Status read showing the transmit code, or holding write, clears the transmit interrupt.
// - Reading the receive holding register clears the time-out interrupt.
// - Status bit 0 reads one when nothing is pending, zero otherwise.
module uci_channel_irq
  import uci_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int CHAR_BITS = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData_q,
  // Receiver side
  input wire logic rxCharValid,
  input wire uci_rx_char_t rxChar,
  input wire logic bitTick,
  // Transmitter side
  input wire logic txPop,
  input wire logic txShiftEmpty,
  output logic txPushValid_q,
  output logic [7:0] txPushData_q,
  // Modem pins and flow control
  input wire uci_modem_pins_t modemPins,
  input wire logic rxFlowHold,
  input wire uci_flow_evt_t flowEvt,
  output logic rtsPinN_q,
  output logic dtrPinN_q,
  output uci_flow_chars_t flowChars_q,
  output logic [3:0] softFlowSel_q,
  // Device-level summary
  output logic irqRequest_q,
  output logic [5:0] irqCode_q
);

  localparam int LW = $clog2(DEPTH) + 1;
  localparam logic [7:0] TOUT_LIMIT = 8'(`UCI_TOUT_CHARS * CHAR_BITS + `UCI_TOUT_BITS);

  function automatic logic [4:0] trigLevel(input logic [1:0] sel);
    case (sel)
      2'h0: trigLevel = `UCI_TRIG_0;
      2'h1: trigLevel = `UCI_TRIG_1;
      2'h2: trigLevel = `UCI_TRIG_2;
      default: trigLevel = `UCI_TRIG_3;
    endcase
  endfunction

  function automatic logic rising(input logic prev, input logic now);
    rising = !prev && now;
  endfunction

  // --------------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------------
  logic wrHit [16];
  logic rdHit [16];
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      wrHit[i] = regWr && (regAddr == 4'(i));
      rdHit[i] = regRd && (regAddr == 4'(i));
    end
  end

  logic [7:0] ier_q;
  logic [7:0] lcr_q;
  logic [7:0] mcr_q;
  logic [7:0] scratch_q;
  logic [7:0] feature_control_q;
  logic [7:0] efr_q;
  logic fifoEn_q;
  logic [1:0] rxTrigSel_q;
  logic [1:0] txTrigSel_q;
  logic [7:0] ierEff;
  logic fcrWr;
  logic rxFlush;
  logic txFlush;

  assign fcrWr = wrHit[`UCI_OFS_IRQ_STATUS];
  assign rxFlush = fcrWr && (regWrData[`UCI_FCR_RX_RESET] || (regWrData[`UCI_FCR_ENABLE] != fifoEn_q));
  assign txFlush = fcrWr && (regWrData[`UCI_FCR_TX_RESET] || (regWrData[`UCI_FCR_ENABLE] != fifoEn_q));
  // Upper mask bits count only while enhanced functions are on; bit 4 stays zero
  assign ierEff = {ier_q[7:5] & {3{efr_q[`UCI_EFR_ENH]}}, 1'b0, ier_q[3:0]};

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ier_q <= `UCI_RST_IRQ_ENABLE;
    end
    else if (wrHit[`UCI_OFS_IRQ_ENABLE])
    begin
      ier_q[3:0] <= regWrData[3:0];
      if (efr_q[`UCI_EFR_ENH])
      begin
        ier_q[7:5] <= regWrData[7:5];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      lcr_q <= `UCI_RST_CTRL;
      mcr_q <= `UCI_RST_CTRL;
      scratch_q <= `UCI_RST_CTRL;
      feature_control_q <= `UCI_RST_CTRL;
      efr_q <= `UCI_RST_CTRL;
      flowChars_q <= {4{`UCI_RST_CHAR}};
    end
    else
    begin
      if (wrHit[`UCI_OFS_LINE_CONTROL]) lcr_q <= regWrData;
      if (wrHit[`UCI_OFS_MODEM_CONTROL]) mcr_q <= regWrData;
      if (wrHit[`UCI_OFS_SCRATCH]) scratch_q <= regWrData;
      if (wrHit[`UCI_OFS_FEATURE_CONTROL]) feature_control_q <= regWrData;
      if (wrHit[`UCI_OFS_ENHANCED]) efr_q <= regWrData;
      if (wrHit[`UCI_OFS_FLOW_IND]) flowChars_q.pauseFirst <= regWrData;
      if (wrHit[`UCI_OFS_PAUSE_SECOND]) flowChars_q.pauseSecond <= regWrData;
      if (wrHit[`UCI_OFS_RESUME_FIRST]) flowChars_q.resumeFirst <= regWrData;
      if (wrHit[`UCI_OFS_RESUME_SECOND]) flowChars_q.resumeSecond <= regWrData;
    end
  end

  // Trigger select bits only program when the enable bit is written as one; reset bits act either way
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      fifoEn_q <= 1'b0;
      rxTrigSel_q <= `UCI_RST_TRIG_SEL;
      txTrigSel_q <= `UCI_RST_TRIG_SEL;
    end
    else if (fcrWr)
    begin
      fifoEn_q <= regWrData[`UCI_FCR_ENABLE];
      if (regWrData[`UCI_FCR_ENABLE])
      begin
        rxTrigSel_q <= regWrData[7:6];
        if (efr_q[`UCI_EFR_ENH])
        begin
          txTrigSel_q <= regWrData[5:4];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive path
  // --------------------------------------------------------------------------
  logic [LW-1:0] limit;
  logic [LW-1:0] rxLevel;
  logic [LW-1:0] rxTrig;
  logic [LW-1:0] txTrig;
  uci_rx_char_t rxHead;
  logic rxHeadErr;
  logic rxFull;
  logic rxPushOk;
  logic rxPushErr;
  logic rhrRead;
  logic rxPopDone_q;
  logic [LW-1:0] errCount_q;
  logic overrun_q;
  logic lineFlag_q;
  logic [7:0] toutCnt_q;
  logic toutFlag_q;
  logic lsrRead;

  assign limit = fifoEn_q ? LW'(DEPTH) : LW'(1);
  assign rxTrig = fifoEn_q ? LW'(trigLevel(rxTrigSel_q)) : LW'(1);
  assign txTrig = fifoEn_q ? LW'(trigLevel(txTrigSel_q)) : LW'(1);
  assign rxFull = rxLevel >= limit;
  assign rxPushOk = rxCharValid && !rxFull;
  assign rxPushErr = rxPushOk && (rxChar.brk || rxChar.framing || rxChar.parity);
  assign rhrRead = rdHit[`UCI_OFS_HOLDING];
  assign lsrRead = rdHit[`UCI_OFS_LINE_STATUS];
  assign rxHeadErr = (rxLevel != '0) && (rxHead.brk || rxHead.framing || rxHead.parity);

  uci_rx_fifo #(
    .WIDTH($bits(uci_rx_char_t)),
    .DEPTH(DEPTH),
    .LW(LW)
  ) rxFifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .flush(rxFlush),
    .limit(limit),
    .pushValid(rxCharValid),
    .pushData(rxChar),
    .popReq(rhrRead),
    .headData_q(rxHead),
    .level_q(rxLevel)
  );

  // Errored characters held in the FIFO
  always_ff @(posedge sys_clk)
  begin
    if (srst || rxFlush)
    begin
      errCount_q <= '0;
      rxPopDone_q <= 1'b0;
    end
    else
    begin
      errCount_q <= errCount_q + LW'(rxPushErr) - LW'(rhrRead && rxHeadErr);
      rxPopDone_q <= rhrRead && (rxLevel != '0);
    end
  end

  // Overrun and line flags; a new event beats the clearing read
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      overrun_q <= 1'b0;
      lineFlag_q <= 1'b0;
    end
    else
    begin
      overrun_q <= (overrun_q && !lsrRead) || (rxCharValid && rxFull);
      lineFlag_q <= (lineFlag_q && !lsrRead)
        || rxPushErr || (rxCharValid && rxFull)
        || (rxPopDone_q && rxHeadErr);
    end
  end

  // Time-out counts bit times while data waits unread
  always_ff @(posedge sys_clk)
  begin
    if (srst || rxFlush || rxPushOk || rhrRead || (rxLevel == '0) || !fifoEn_q)
    begin
      toutCnt_q <= '0;
    end
    else if (bitTick && (toutCnt_q < TOUT_LIMIT))
    begin
      toutCnt_q <= toutCnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      toutFlag_q <= 1'b0;
    end
    else
    begin
      toutFlag_q <= (toutFlag_q && !rhrRead && !rxFlush)
        || (bitTick && (toutCnt_q == TOUT_LIMIT - 8'h01));
    end
  end

  // --------------------------------------------------------------------------
  // Transmit path
  // --------------------------------------------------------------------------
  logic [LW-1:0] txLevel_q;
  logic [LW-1:0] txLevel_d;
  logic thrWrite;
  logic txAccept;
  logic txAllEmpty;
  logic txAllEmpty_q;
  logic txEmptyEvt;
  logic txFlag_q;
  logic isrRead;
  logic [5:0] code;

  assign thrWrite = wrHit[`UCI_OFS_HOLDING];
  assign txAccept = thrWrite && (txLevel_q < limit);
  assign txLevel_d = txLevel_q + LW'(txAccept) - LW'(txPop && (txLevel_q != '0));
  assign txAllEmpty = (txLevel_q == '0) && txShiftEmpty;
  assign isrRead = rdHit[`UCI_OFS_IRQ_STATUS];
  // Half-duplex holds the empty event until the shifter is idle as well
  assign txEmptyEvt = feature_control_q[`UCI_FEATURE_CONTROL_HALF_DUPLEX] ? rising(txAllEmpty_q, txAllEmpty)
    : ((txLevel_q != '0) && (txLevel_d == '0));

  always_ff @(posedge sys_clk)
  begin
    if (srst || txFlush)
    begin
      txLevel_q <= '0;
    end
    else
    begin
      txLevel_q <= txLevel_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      txPushValid_q <= 1'b0;
      txPushData_q <= 8'h00;
      txAllEmpty_q <= 1'b1;
      txFlag_q <= 1'b0;
    end
    else
    begin
      txPushValid_q <= txAccept;
      txPushData_q <= thrWrite ? regWrData : txPushData_q;
      txAllEmpty_q <= txAllEmpty;
      txFlag_q <= (txFlag_q && !thrWrite && !(isrRead && (code == `UCI_CODE_TX_READY_IRQ)))
        || ((txLevel_q >= txTrig) && (txLevel_d < txTrig)) || txEmptyEvt;
    end
  end

  // --------------------------------------------------------------------------
  // Modem status and flow-control events
  // --------------------------------------------------------------------------
  uci_modem_pins_t pinsPrev_q;
  logic [3:0] msrDelta_q;
  logic inFlowFlag_q;
  logic outFlowFlag_q;
  logic pauseFlag_q;
  logic [3:0] flowInd_q;
  logic msrRead;
  logic inPinNow;
  logic inPinPrev;
  logic rtsNext;
  logic dtrNext;
  logic outPinNow;
  logic outPinPrev;

  assign msrRead = rdHit[`UCI_OFS_MODEM_STATUS];
  assign inPinNow = mcr_q[`UCI_MCR_FLOW_SEL] ? modemPins.dsrN : modemPins.ctsN;
  assign inPinPrev = mcr_q[`UCI_MCR_FLOW_SEL] ? pinsPrev_q.dsrN : pinsPrev_q.ctsN;
  assign rtsNext = !mcr_q[`UCI_MCR_RTS]
    || (efr_q[`UCI_EFR_AUTO_OUT] && !mcr_q[`UCI_MCR_FLOW_SEL] && rxFlowHold);
  assign dtrNext = !mcr_q[`UCI_MCR_DTR]
    || (efr_q[`UCI_EFR_AUTO_OUT] && mcr_q[`UCI_MCR_FLOW_SEL] && rxFlowHold);
  assign outPinNow = mcr_q[`UCI_MCR_FLOW_SEL] ? dtrNext : rtsNext;
  assign outPinPrev = mcr_q[`UCI_MCR_FLOW_SEL] ? dtrPinN_q : rtsPinN_q;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pinsPrev_q <= 4'hf;
      msrDelta_q <= 4'h0;
      inFlowFlag_q <= 1'b0;
      outFlowFlag_q <= 1'b0;
      rtsPinN_q <= 1'b1;
      dtrPinN_q <= 1'b1;
    end
    else
    begin
      pinsPrev_q <= modemPins;
      rtsPinN_q <= rtsNext;
      dtrPinN_q <= dtrNext;
      msrDelta_q <= (msrDelta_q & {4{!msrRead}}) | (pinsPrev_q ^ modemPins);
      inFlowFlag_q <= (inFlowFlag_q && !msrRead)
        || (efr_q[`UCI_EFR_AUTO_IN] && rising(inPinPrev, inPinNow));
      outFlowFlag_q <= (outFlowFlag_q && !msrRead)
        || (efr_q[`UCI_EFR_AUTO_OUT] && rising(outPinPrev, outPinNow));
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pauseFlag_q <= 1'b0;
      flowInd_q <= 4'h0;
      softFlowSel_q <= 4'h0;
    end
    else
    begin
      pauseFlag_q <= (pauseFlag_q && !flowEvt.rxResume && !(isrRead && (code == `UCI_CODE_PAUSE)))
        || flowEvt.rxPause;
      flowInd_q <= (flowInd_q & {4{!rdHit[`UCI_OFS_FLOW_IND]}}) | flowEvt;
      softFlowSel_q <= efr_q[3:0];
    end
  end

  // --------------------------------------------------------------------------
  // Priority and status
  // --------------------------------------------------------------------------
  logic rxDataPend;
  logic anyPend;

  // Level-driven: follows the FIFO level against the trigger
  assign rxDataPend = ierEff[`UCI_IER_RXDATA] && (rxLevel >= rxTrig);

  always_comb
  begin
    code = `UCI_CODE_NONE;
    if (ierEff[`UCI_IER_LINE] && lineFlag_q) code = `UCI_CODE_LINE;
    else if (rxDataPend) code = `UCI_CODE_RXDATA;
    else if (ierEff[`UCI_IER_RXDATA] && toutFlag_q) code = `UCI_CODE_TIMEOUT;
    else if (ierEff[`UCI_IER_TX_READY_IRQ] && txFlag_q) code = `UCI_CODE_TX_READY_IRQ;
    else if (ierEff[`UCI_IER_MODEM] && (msrDelta_q != 4'h0)) code = `UCI_CODE_MODEM;
    else if (ierEff[`UCI_IER_PAUSE] && pauseFlag_q) code = `UCI_CODE_PAUSE;
    else if ((ierEff[`UCI_IER_IN_FLOW] && inFlowFlag_q) || (ierEff[`UCI_IER_OUT_FLOW] && outFlowFlag_q))
      code = `UCI_CODE_FLOW_CHG;
  end

  assign anyPend = (code != `UCI_CODE_NONE);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      irqRequest_q <= 1'b0;
      irqCode_q <= `UCI_CODE_NONE;
    end
    else
    begin
      irqRequest_q <= anyPend;
      irqCode_q <= code;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [7:0] rdMux;
  logic [7:0] lineStatus;

  // Polled use reads these bits directly, whatever the mask
  assign lineStatus = {(errCount_q != '0),
    txAllEmpty, (txLevel_q == '0),
    (rxLevel != '0) ? {rxHead.brk, rxHead.framing, rxHead.parity} : 3'h0,
    overrun_q, (rxLevel != '0)};

  always_comb
  begin
    rdMux = 8'h00;
    case (regAddr)
      `UCI_OFS_HOLDING: rdMux = rxHead.data;
      `UCI_OFS_IRQ_ENABLE: rdMux = ierEff;
      `UCI_OFS_IRQ_STATUS: rdMux = {{2{fifoEn_q}}, code};
      `UCI_OFS_LINE_CONTROL: rdMux = lcr_q;
      `UCI_OFS_MODEM_CONTROL: rdMux = mcr_q;
      `UCI_OFS_LINE_STATUS: rdMux = lineStatus;
      `UCI_OFS_MODEM_STATUS: rdMux = {~modemPins, msrDelta_q};
      `UCI_OFS_SCRATCH: rdMux = scratch_q;
      `UCI_OFS_FEATURE_CONTROL: rdMux = feature_control_q;
      `UCI_OFS_ENHANCED: rdMux = efr_q;
      `UCI_OFS_FLOW_IND: rdMux = {4'h0, flowInd_q};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      regRdData_q <= 8'h00;
    end
    else
    begin
      regRdData_q <= regRd ? rdMux : 8'h00;
    end
  end

endmodule

// file: tb/uci_channel_irq_assertions.sv
/*
  Port checker for the channel interrupt logic.
  Assumes it is bound to uci_channel_irq.
*/
`timescale 1ns/1ps
module uci_channel_irq_assertions
  import uci_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData_q,
  // Events and summary
  input wire logic rxCharValid,
  input wire uci_flow_evt_t flowEvt,
  input wire logic irqRequest_q,
  input wire logic [5:0] irqCode_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ----------
  // Properties
  // ----------
  sequence s_rdc;
    regRd && regAddr == 4'hc && flowEvt == 0;
  endsequence
  sequence s_gate;
    regWr && regAddr == 4'h9 && !regWrData[4] ##2 regWr && regAddr == 4'h1;
  endsequence
  property p_rst;
    $fell(srst) |-> irqCode_q == 6'h01;
  endproperty
  a_rst: assert property (p_rst)
    else $error("code not idle after reset");
  property p_isr0;
    regRd && regAddr == 4'h2 |=> regRdData_q[0] == (regRdData_q[5:0] == 6'h01);
  endproperty
  a_isr0: assert property (p_isr0)
    else $error("status bit 0 wrong");
  property p_req;
    irqRequest_q == (irqCode_q != 6'h01);
  endproperty
  a_req: assert property (p_req)
    else $error("request disagrees with code");
  property p_ind;
    regRd && regAddr == 4'hc |=> regRdData_q[7:4] == 4'h0;
  endproperty
  a_ind: assert property (p_ind)
    else $error("indicator upper bits set");
  property p_clr;
    s_rdc ##1 flowEvt == 0 ##1 s_rdc |=> regRdData_q == 8'h00;
  endproperty
  a_clr: assert property (p_clr)
    else $error("indicators not cleared");
  property p_rdy;
    rxCharValid && !regRd && !regWr ##1 !regRd && !regWr ##1 regRd && regAddr == 4'h5 |=> regRdData_q[0];
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("data ready missing");
  property p_err;
    regRd && regAddr == 4'h5 |=> (!(|regRdData_q[4:2]) || regRdData_q[7]) && (!regRdData_q[6] || regRdData_q[5]);
  endproperty
  a_err: assert property (p_err)
    else $error("line status flags inconsistent");
  property p_gate;
    s_gate ##2 regRd && regAddr == 4'h1 |=> regRdData_q[7:5] == 3'h0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("upper mask bits took effect");
endmodule

bind uci_channel_irq uci_channel_irq_assertions chk_i (.sys_clk, .srst, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData_q, .rxCharValid, .flowEvt, .irqRequest_q, .irqCode_q);

// file: tb/uci_line_model.sv
/*
  Serial line partner: offers received characters and modem pin levels.
  Assumes its tasks are called from the bench.
*/
`timescale 1ns/1ps
module uci_line_model
  import uci_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Line side
  output logic rxCharValid = 1'b0,
  output uci_rx_char_t rxChar = 11'h000,
  output uci_modem_pins_t modemPins = 4'hf
);
  task send(input uci_rx_char_t c);
    @(posedge sys_clk);
    {rxCharValid, rxChar} <= {1'b1, c};
    @(posedge sys_clk);
    // Released data goes to the inverse so a stale value never matches
    {rxCharValid, rxChar} <= {1'b0, ~c};
  endtask
  task pin(input uci_modem_pins_t p);
    @(posedge sys_clk);
    modemPins <= p;
  endtask
endmodule

// file: tb/tb_top.sv
/*
  Bench for uci_channel_irq: register tasks and checked sequences.
  Assumes the line model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top
  import uci_pkg::*;
;
  logic sys_clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, rxCharValid, irqRequest_q;
  logic txPop = 1'b0, txShiftEmpty = 1'b1, txPushValid_q;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData_q, d, txPushData_q;
  logic [5:0] irqCode_q;
  uci_rx_char_t rxChar;
  uci_modem_pins_t modemPins;
  uci_flow_evt_t flowEvt = 4'h0;
  int n_mismatch = 0, check_count = 0;
  always #2 sys_clk = ~sys_clk;
  uci_line_model lm (.sys_clk, .rxCharValid, .rxChar, .modemPins);
  uci_channel_irq dut (.sys_clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q,
    .rxCharValid, .rxChar, .bitTick(1'b0), .txPop, .txShiftEmpty, .txPushValid_q,
    .txPushData_q, .modemPins, .rxFlowHold(1'b0), .flowEvt, .rtsPinN_q(), .dtrPinN_q(),
    .flowChars_q(), .softFlowSel_q(), .irqRequest_q, .irqCode_q);
  // ----------
  // Tasks
  // ----------
  task chk(input logic [7:0] s, e);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h not %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    {regWr, regAddr, regWrData} <= {1'b1, a, v};
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    {regRd, regAddr} <= {1'b1, a};
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdData_q;
    chk(d, e);
  endtask
  task ev(input uci_flow_evt_t f);
    @(posedge sys_clk);
    flowEvt <= f;
    @(posedge sys_clk);
    flowEvt <= 4'h0;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    complete_run;
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    rc(4'h1, 8'h00);
    rc(4'h2, 8'h01);
    wr(4'h9, 8'h00);
    wr(4'h1, 8'hff);
    rc(4'h1, 8'h0f);
    $display("test reset and mask done");
    wr(4'h2, 8'h01);
    wr(4'h9, 8'h10);
    wr(4'h1, 8'h05);
    lm.send({8'h55, 3'h0});
    rc(4'h5, 8'h61);
    lm.send({8'haa, 3'h1});
    rc(4'h2, 8'hc6);
    chk({7'h0, irqRequest_q}, 8'h01);
    rc(4'h5, 8'he1);
    rc(4'h2, 8'hc4);
    rc(4'h0, 8'h55);
    repeat (2) @(posedge sys_clk);
    rc(4'h2, 8'hc6);
    rc(4'h5, 8'he5);
    rc(4'h0, 8'haa);
    rc(4'h2, 8'hc1);
    chk({7'h0, irqRequest_q}, 8'h00);
    $display("test receive done");
    wr(4'h1, 8'h20);
    ev(4'h1);
    rc(4'h2, 8'hd0);
    rc(4'h2, 8'hc1);
    ev(4'he);
    rc(4'hc, 8'h0f);
    rc(4'hc, 8'h00);
    wr(4'h9, 8'h90);
    wr(4'h1, 8'h80);
    lm.pin(4'he);
    lm.pin(4'hf);
    rc(4'h2, 8'he0);
    chk({2'h0, irqCode_q}, 8'h20);
    rc(4'h6, 8'h01);
    rc(4'h2, 8'hc1);
    $display("test flow done");
    wr(4'h1, 8'h02);
    wr(4'h0, 8'h3c);
    #1 chk({7'h0, txPushValid_q}, 8'h01);
    chk(txPushData_q, 8'h3c);
    @(posedge sys_clk) {txPop, txShiftEmpty} <= 2'b10;
    @(posedge sys_clk) txPop <= 1'b0;
    rc(4'h5, 8'h20);
    rc(4'h2, 8'hc2);
    rc(4'h2, 8'hc1);
    $display("test transmit done");
    complete_run;
  end
endmodule
